/* verilog/conv_ctrl_pkg.sv */
/*
  shared constants and carrier types of the converter control block:
  register map, field layout, reset values, divider ratios, timing counts.
  assumes a 125 MHz system clock and a 32-bit avalon-mm register port.
*/
package conv_ctrl_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] rate_reg_addr = 4'h0;
  localparam logic [3:0] reference_control_register_addr = 4'h4;
  localparam logic [3:0] excitation_reg_addr = 4'h8;
  localparam logic [3:0] control_reg_addr = 4'hc;
  localparam logic [3:0] status_reg_addr = 4'h0;
  localparam logic [3:0] result_reg_addr = 4'h4;
  // read-only block sits at byte 0x10 and up
  localparam logic [4:0] status_off = 5'h10;
  localparam logic [4:0] result_off = 5'h14;
  localparam logic [4:0] sample_cnt_off = 5'h18;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int rate_w = 4;
  localparam int refsel_w = 2;
  localparam int refsel_pos = 0;
  localparam int refen_pos = 4;
  localparam int refgpio_pos = 5;
  localparam int mag_w = 3;
  localparam int mag_pos = 0;
  localparam int route_a_pos = 4;
  localparam int route_b_pos = 6;
  localparam int start_pos = 0;
  localparam int extclk_pos = 1;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] rate_rst = 4'h0;
  localparam logic [1:0] refsel_rst = 2'h0;
  localparam logic refen_rst = 1'b0;
  localparam logic [2:0] mag_rst = 3'h0;
  localparam logic [1:0] route_rst = 2'h3;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int clk_mhz = 125;
  localparam int filt_reset_mod_cycles = 32;
  localparam int nom_clk_khz = 4096;

  // data rate codes 0..9: 5,10,20,40,80,160,320,640,1000,2000 sps
  typedef enum logic [1:0] {div_128, div_32, div_16, div_8} mod_div_e;

  typedef struct packed {
    logic [rate_w-1:0] rate;
    logic [refsel_w-1:0] refsel;
    logic refen;
    logic refgpio;
    logic [mag_w-1:0] mag;
    logic [1:0] route_a;
    logic [1:0] route_b;
    logic start;
  } cfg_s;

  typedef struct packed {
    logic busy;
    logic filt_reset;
    logic ready;
    logic excitation_current_source_live;
  } stat_s;

endpackage

/* verilog/mod_clk_div.sv */
/*
  modulator clock divider: turns system clock ticks into one-cycle
  modulator enables, ratio picked by the rate setting.
  assumes sys_tick is one cycle wide and already on the clock domain.
*/
`timescale 1ns/1ps
module mod_clk_div #(
  parameter int cnt_w = 7
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic sys_tick,
  input wire conv_ctrl_pkg::mod_div_e ratio,
  output logic mod_tick
);

  typedef struct packed {
    logic [cnt_w-1:0] cnt;
    logic tick;
  } st_s;

  st_s st_q;
  st_s st_d;
  logic [cnt_w-1:0] last;

  always_comb begin
    unique case (ratio)
      conv_ctrl_pkg::div_128: last = cnt_w'(127);
      conv_ctrl_pkg::div_32: last = cnt_w'(31);
      conv_ctrl_pkg::div_16: last = cnt_w'(15);
      conv_ctrl_pkg::div_8: last = cnt_w'(7);
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (sys_tick) begin
      if (st_q.cnt >= last) begin
        st_d.cnt = '0;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + cnt_w'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mod_tick = st_q.tick;

endmodule

/* verilog/adc_rate_reference_excitation_current_source_ctrl.sv */
/*
  control logic of a delta-sigma converter: rate selection, modulator
  clock enables, decimation filter sequencing, reference multiplexer,
  internal reference enable and excitation current source settings.
  assumes an avalon-mm master on clock, a system clock tick pin that may
  come from the internal oscillator or an external pin, and a 1-bit
  modulator bitstream sampled on modulator ticks.
*/
`timescale 1ns/1ps

module adc_rate_reference_excitation_current_source_ctrl #(
  parameter int acc_w = 24
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic int_osc_tick,
  input wire logic ext_clk_pin,
  input wire logic modulator_bit,
  output logic [1:0] reference_select,
  output logic internal_reference_output_en,
  output logic reference_pair_zero_gpio_en,
  output logic [2:0] excitation_current_source_mag,
  output logic [1:0] excitation_output_pin_a_src,
  output logic [1:0] excitation_output_pin_b_src,
  output logic ext_clk_active,
  output logic data_ready
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic conv_ctrl_pkg::mod_div_e rate_div(
    input logic [3:0] r
  );
    if (r <= 4'h2) begin
      return conv_ctrl_pkg::div_128;
    end else if (r <= 4'h5) begin
      return conv_ctrl_pkg::div_32;
    end else if (r <= 4'h8) begin
      return conv_ctrl_pkg::div_16;
    end
    return conv_ctrl_pkg::div_8;
  endfunction

  // modulator samples per output word at the nominal clock
  function automatic logic [15:0] rate_osr(input logic [3:0] r);
    logic [15:0] n;
    n = 16'h0000;
    unique case (r)
      4'h0: n = 16'h18e8;
      4'h1: n = 16'h0c74;
      4'h2: n = 16'h063a;
      4'h3: n = 16'h0c74;
      4'h4: n = 16'h063a;
      4'h5: n = 16'h031d;
      4'h6: n = 16'h031c;
      4'h7: n = 16'h018e;
      4'h8: n = 16'h0100;
      default: n = 16'h0100;
    endcase
    return n;
  endfunction

  typedef enum logic [1:0] {st_idle, st_settle, st_accum} seq_e;

  typedef struct packed {
    conv_ctrl_pkg::cfg_s cfg;
    seq_e seq;
    logic [5:0] settle_cnt;
    logic [15:0] samp_cnt;
    logic [acc_w-1:0] acc;
    logic [acc_w-1:0] result;
    logic ready;
    logic ext_sel;
    logic [2:0] ext_sync;
    logic ext_prev;
    logic [2:0] osc_div;
    logic [31:0] rdata;
    logic rvalid;
    logic start_prev;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic sys_tick;
  logic mod_tick;
  logic ext_edge;
  logic [31:0] wmask;
  logic acc_start;

  // ------------------------------------------------------------------
  // system clock source
  // ------------------------------------------------------------------
  // rising edge seen only once sync stages two and three agree
  assign ext_edge = s_q.ext_sync[1] & s_q.ext_sync[2] & ~s_q.ext_prev;
  assign sys_tick = s_q.ext_sel ? ext_edge : int_osc_tick;

  mod_clk_div #(
    .cnt_w(7)
  ) u_div (
    .clock(clock),
    .srst(srst),
    .sys_tick(sys_tick),
    .ratio(rate_div(s_q.cfg.rate)),
    .mod_tick(mod_tick)
  );

  always_comb begin
    wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
             {8{byteenable[1]}}, {8{byteenable[0]}}};
  end

  assign acc_start = s_q.cfg.start & ~s_q.start_prev;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.start_prev = s_q.cfg.start;
    s_d.ext_sync = {s_q.ext_sync[1:0], ext_clk_pin};
    if (s_q.ext_sync[1] == s_q.ext_sync[2]) begin
      s_d.ext_prev = s_q.ext_sync[2];
    end
    if (ext_edge) begin
      s_d.ext_sel = 1'b1;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // upper block is read-only, so writes there must not alias
    if (write && !s_q.rvalid && !address[4]) begin
      unique case (address[3:0])
        conv_ctrl_pkg::rate_reg_addr: begin
          if (byteenable[0] && writedata[3:0] <= 4'h9) begin
            s_d.cfg.rate = writedata[3:0];
          end
        end
        conv_ctrl_pkg::reference_control_register_addr: begin
          if (byteenable[0]) begin
            s_d.cfg.refsel =
              writedata[conv_ctrl_pkg::refsel_pos +: 2];
            s_d.cfg.refen = writedata[conv_ctrl_pkg::refen_pos];
            s_d.cfg.refgpio = writedata[conv_ctrl_pkg::refgpio_pos];
          end
        end
        conv_ctrl_pkg::excitation_reg_addr: begin
          if (byteenable[0]) begin
            s_d.cfg.mag = writedata[conv_ctrl_pkg::mag_pos +: 3];
            s_d.cfg.route_a = writedata[conv_ctrl_pkg::route_a_pos +: 2];
            s_d.cfg.route_b = writedata[conv_ctrl_pkg::route_b_pos +: 2];
          end
        end
        conv_ctrl_pkg::control_reg_addr: begin
          if (byteenable[0]) begin
            s_d.cfg.start = writedata[conv_ctrl_pkg::start_pos];
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // register reads, one wait cycle
    // ----------------------------------------------------------------
    if ((read || write) && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (read) begin
        unique case (address)
          5'h00: s_d.rdata[3:0] = s_q.cfg.rate;
          5'h04: s_d.rdata[5:0] = {s_q.cfg.refgpio, s_q.cfg.refen,
                                  2'b00, s_q.cfg.refsel};
          5'h08: s_d.rdata[7:0] = {s_q.cfg.route_b, s_q.cfg.route_a,
                                  1'b0, s_q.cfg.mag};
          5'h0c: s_d.rdata[1:0] = {s_q.ext_sel, s_q.cfg.start};
          conv_ctrl_pkg::status_off:
            s_d.rdata[2:0] = {s_q.ready, s_q.seq == st_settle,
                              s_q.seq != st_idle};
          conv_ctrl_pkg::result_off:
            s_d.rdata[acc_w-1:0] = s_q.result;
          conv_ctrl_pkg::sample_cnt_off:
            s_d.rdata[15:0] = s_q.samp_cnt;
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
      if (read && address == conv_ctrl_pkg::result_off) begin
        s_d.ready = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    unique case (s_q.seq)
      st_idle: begin
        if (s_q.cfg.start) begin
          s_d.seq = st_settle;
          s_d.settle_cnt = '0;
        end
      end
      st_settle: begin
        // hold filter for 32 modulator cycles
        if (mod_tick) begin
          if (s_q.settle_cnt ==
              6'(conv_ctrl_pkg::filt_reset_mod_cycles - 1)) begin
            s_d.seq = st_accum;
            s_d.samp_cnt = '0;
            s_d.acc = '0;
          end else begin
            s_d.settle_cnt = s_q.settle_cnt + 6'h01;
          end
        end
      end
      st_accum: begin
        if (mod_tick) begin
          s_d.acc = s_q.acc + acc_w'(modulator_bit);
          s_d.samp_cnt = s_q.samp_cnt + 16'h0001;
          if (s_q.samp_cnt == rate_osr(s_q.cfg.rate) - 16'h0001) begin
            s_d.result = s_q.acc + acc_w'(modulator_bit);
            s_d.ready = 1'b1;
            s_d.samp_cnt = '0;
            s_d.acc = '0;
            if (!s_q.cfg.start) begin
              s_d.seq = st_idle;
            end
          end
        end
      end
    endcase
    // restart on a rising edge of start only, set beats clear of ready
    if (acc_start) begin
      s_d.seq = st_settle;
      s_d.settle_cnt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
      s_q.cfg.rate <= conv_ctrl_pkg::rate_rst;
      s_q.cfg.refsel <= conv_ctrl_pkg::refsel_rst;
      s_q.cfg.refen <= conv_ctrl_pkg::refen_rst;
      s_q.cfg.mag <= conv_ctrl_pkg::mag_rst;
      s_q.cfg.route_a <= conv_ctrl_pkg::route_rst;
      s_q.cfg.route_b <= conv_ctrl_pkg::route_rst;
      s_q.seq <= st_idle;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign readdata = s_q.rdata;
  assign waitrequest = ~s_q.rvalid;
  assign reference_select = s_q.cfg.refsel;
  assign internal_reference_output_en = s_q.cfg.refen;
  assign reference_pair_zero_gpio_en = s_q.cfg.refgpio;
  assign excitation_current_source_mag =
    s_q.cfg.refen ? s_q.cfg.mag : 3'h0;
  assign excitation_output_pin_a_src = s_q.cfg.route_a;
  assign excitation_output_pin_b_src = s_q.cfg.route_b;
  assign ext_clk_active = s_q.ext_sel;
  assign data_ready = s_q.ready;

endmodule

/* bench/conv_ctrl_properties.sv */
/* port assertions of the converter control block
   assumes bind into the block top */
`timescale 1ns/1ps
module conv_ctrl_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] reference_select,
  input wire logic internal_reference_output_en,
  input wire logic reference_pair_zero_gpio_en,
  input wire logic [2:0] excitation_current_source_mag,
  input wire logic [1:0] excitation_output_pin_a_src,
  input wire logic [1:0] excitation_output_pin_b_src,
  input wire logic ext_clk_active,
  input wire logic data_ready
);
  logic [3:0] ref_q;
  wire take = waitrequest && (read || write);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  always_ff @(posedge clock) begin
    if (take && write && address == 5'h04) begin
      ref_q <= {writedata[5:4], writedata[1:0]};
    end
  end
  a_answer_next: assert property (take |=> !waitrequest)
    else $error("request not answered");
  a_answer_once: assert property (!waitrequest |=> waitrequest)
    else $error("answer too long");
  a_ref_write: assert property (take && write && address == 5'h04
    |-> ##[2:3] {reference_pair_zero_gpio_en, internal_reference_output_en,
    reference_select} == ref_q) else $error("reference fields not applied");
  a_mag_gated: assert property (!internal_reference_output_en
    |-> excitation_current_source_mag == 3'h0)
    else $error("current source on without reference");
  a_reset_state: assert property ($fell(srst)
    |-> !internal_reference_output_en && !ext_clk_active &&
    {excitation_output_pin_a_src, excitation_output_pin_b_src} == 4'hf)
    else $error("bad state after reset");
  a_ext_sticky: assert property (ext_clk_active |=> ext_clk_active)
    else $error("external clock flag dropped");
  a_unmapped_zero: assert property (take && read && address == 5'h1c
    |=> readdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_ready_clear: assert property (take && read && address == 5'h14
    |-> ##[2:3] !data_ready) else $error("ready not cleared");
  c_result: cover property (data_ready);
  c_ext: cover property ($rose(ext_clk_active));
  c_mag_top: cover property (excitation_current_source_mag == 3'h7);
endmodule

bind adc_rate_reference_excitation_current_source_ctrl conv_ctrl_properties chk (.*);

/* bench/host_model.sv */
/* host bus master on the register port
   assumes an answer within 50 clocks after each request */
`timescale 1ns/1ps
module host_model #(
  parameter int settle_cyc = 300000
) (
  input wire logic clock,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h1;
  end
  task automatic xfer(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q, output bit ok);
    ok = 1'b0;
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clock);
      ok = (waitrequest === 1'b0);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d;
  endtask
  task automatic ref_on(input logic [1:0] sel, output bit ok);
    logic [31:0] q;
    xfer(1'b1, 5'h04, 32'h0000_0010, q, ok);
    repeat (settle_cyc) @(posedge clock);
    xfer(1'b1, 5'h04, {26'h0, 2'h1, 2'h0, sel}, q, ok);
  endtask
endmodule

/* bench/adc_rate_reference_excitation_current_source_ctrl_tb.sv */
/* self-checking bench of the converter control block
   assumes the host model drives the register port */
`timescale 1ns/1ps
module adc_rate_reference_excitation_current_source_ctrl_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic int_osc_tick = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic modulator_bit = 1'b0;
  logic [1:0] bit_mode = 2'h2;
  logic [31:0] lfsr = 32'h6c3d_1962;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] reference_select;
  logic internal_reference_output_en;
  logic reference_pair_zero_gpio_en;
  logic [2:0] excitation_current_source_mag;
  logic [1:0] excitation_output_pin_a_src;
  logic [1:0] excitation_output_pin_b_src;
  logic ext_clk_active;
  logic data_ready;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  adc_rate_reference_excitation_current_source_ctrl dut (.*);
  host_model #(.settle_cyc(64)) host (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always #4 clock = ~clock;
  always @(posedge clock) begin
    lfsr <= nxt(lfsr);
    cyc <= cyc + 1;
    int_osc_tick <= ~int_osc_tick;
    modulator_bit <= bit_mode[1] ? lfsr[0] : bit_mode[0];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      note = exp_q.pop_front();
      check(readdata & note[63:32], note[31:0]);
    end
  end
  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang;
    err_total++;
    end_of_test;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bit ok;
    host.xfer(1'b1, a, d, q, ok);
    if (!ok) hang;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e, output logic [31:0] q);
    bit ok;
    exp_q.push_back({m, e});
    host.xfer(1'b0, a, 32'h0, q, ok);
    if (!ok) hang;
  endtask
  // wait until a status bit reads v
  task automatic poll(input int b, input logic v);
    logic [31:0] q;
    int n;
    for (n = 0; n < 9000; n++) begin
      rd(5'h10, 32'h0, 32'h0, q);
      if (q[b] === v) break;
    end
    if (n == 9000) hang;
  endtask
  task automatic settle;
    repeat (2) @(negedge clock);
  endtask
  initial begin : main
    logic [31:0] q;
    logic [31:0] r;
    logic [3:0] codes [4] = '{4'h2, 4'h3, 4'h6, 4'h9};
    int divs [4] = '{128, 32, 16, 8};
    int t0;
    bit ok;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(5'h04, 32'hffff_ffff, 32'h0000_0000, q);
    rd(5'h08, 32'hffff_ffff, 32'h0000_00f0, q);
    rd(5'h1c, 32'hffff_ffff, 32'h0000_0000, q);
    wr(5'h08, 32'h0000_0007);
    settle;
    check(32'(excitation_current_source_mag), 32'h0);
    host.ref_on(2'h1, ok);
    if (!ok) hang;
    for (int i = 0; i < 4; i++) begin
      wr(5'h04, {26'h0, i[0], 1'b1, 2'h0, i[1:0]});
      settle;
      check(32'(reference_select), 32'(i[1:0]));
      check(32'(reference_pair_zero_gpio_en), 32'(i[0]));
      rd(5'h04, 32'h0000_0033, {26'h0, i[0], 3'h4, i[1:0]}, q);
    end
    for (int i = 1; i < 8; i++) begin
      r = lfsr;
      if (i[0]) r[7:6] = r[5:4];
      wr(5'h08, {24'h0, r[7:4], 1'b0, i[2:0]});
      settle;
      check(32'(excitation_current_source_mag), 32'(i[2:0]));
      check(32'({excitation_output_pin_b_src, excitation_output_pin_a_src}),
        32'(r[7:4]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, {28'h0, codes[i]});
      wr(5'h0c, 32'h0000_0001);
      poll(1, 1'b1);
      t0 = cyc;
      poll(1, 1'b0);
      t0 = cyc - t0;
      check(32'(t0 >= 62 * divs[i] - 8 && t0 <= 64 * divs[i] + 8),
        32'h1);
      wr(5'h0c, 32'h0000_0000);
    end
    wr(5'h00, 32'h0000_000a);
    rd(5'h00, 32'h0000_000f, 32'h0000_0009, q);
    bit_mode <= 2'h1;
    wr(5'h0c, 32'h0000_0001);
    poll(2, 1'b1);
    rd(5'h14, 32'h0, 32'h0, q);
    check(32'(q != 0), 32'h1);
    wr(5'h0c, 32'h0000_0000);
    bit_mode <= 2'h0;
    wr(5'h0c, 32'h0000_0001);
    poll(2, 1'b1);
    rd(5'h14, 32'hffff_ffff, 32'h0000_0000, q);
    settle;
    check(32'(data_ready), 32'h0);
    wr(5'h0c, 32'h0000_0000);
    repeat (16) @(posedge clock) ext_clk_pin <= cyc[1];
    settle;
    check(32'(ext_clk_active), 32'h1);
    rd(5'h0c, 32'h0000_0002, 32'h0000_0002, q);
    @(posedge clock);
    ext_clk_pin <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    settle;
    check(32'(ext_clk_active), 32'h0);
    rd(5'h08, 32'hffff_ffff, 32'h0000_00f0, q);
    end_of_test;
  end
endmodule
